/* hdl/pin_mode_decode.sv */
// decodes one pin's 2-bit field into driver, pull-up and alternate controls
`timescale 1ns/1ns
module pin_mode_decode
    import port_cfg_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic openDrainPort,
    input wire logic pullupBit,
    input wire logic pinOut,
    input wire logic altOut,
    output logic padOe,
    output logic padOut,
    output logic pullupOn,
    output logic altSel
);
    // open-drain ports: 01 drives low only while data is 0; other ports: 01 is pull-up input
    always_comb begin
        padOe = 1'b0;
        padOut = pinOut;
        pullupOn = 1'b0;
        altSel = 1'b0;
        unique case (pin_mode_e'(mode))
            MODE_IN: pullupOn = openDrainPort & pullupBit;
            MODE_LOW: begin
                if (openDrainPort) begin
                    padOe = ~pinOut;
                    padOut = 1'b0;
                    pullupOn = pullupBit;
                end else begin
                    pullupOn = 1'b1;
                end
            end
            MODE_PUSH: padOe = 1'b1;
            MODE_ALT: begin
                altSel = 1'b1;
                padOe = 1'b1;
                padOut = altOut;
            end
        endcase
    end
endmodule : pin_mode_decode

/* hdl/port_cfg_defs.svh */
// register offsets, field positions and reset values for the port configuration bank
`ifndef PORT_CFG_DEFS_SVH
`define PORT_CFG_DEFS_SVH
`define OFS_P2_CFG_HIGH 8'he8
`define OFS_P2_CFG_LOW 8'he9
`define OFS_P3_CFG_HIGH 8'hea
`define OFS_P3_CFG_LOW 8'heb
`define OFS_P4_CFG_HIGH 8'hec
`define OFS_P4_CFG_LOW 8'hed
`define OFS_P4_PULLUP 8'hee
`define OFS_P5_PULLUP 8'hef
`define OFS_P5_CFG_HIGH 8'hf9
`define OFS_P5_CFG_LOW 8'hfa
`define RST_CFG 8'h00
`define P3H_IMPL_MASK 8'h3f
`define P3H_SEL_PIN1 5
`define P3H_SEL_PIN0 4
`endif

/* hdl/port_cfg_pkg.sv */
// types shared by the port configuration bank
package port_cfg_pkg;
    typedef enum logic [1:0] {
        MODE_IN = 2'h0,
        MODE_LOW = 2'h1,
        MODE_PUSH = 2'h2,
        MODE_ALT = 2'h3
    } pin_mode_e;
endpackage : port_cfg_pkg

/* hdl/port_pin_config_bank.sv */
// configuration registers and pin routing for ports 2 to 5
// Summary of operation
// - port 2 fields: input, pull-up input, push-pull, analog; pin 7 also reference
// - port 3 pin 3: inputs feed timer A capture, push-pull, or segment 37
// - port 3 pins 1/0 alternate source picked by high byte bits 5/4
// - port 4 fields: input, open-drain, push-pull, segments 18 to 25
// - port 4 pull-up enable register, one bit per pin
// - port 4 pull-up forced off in push-pull or alternate mode
// - port 5 fields: input, open-drain, push-pull, segments 26 to 33
// - port 5 pull-up forced off in push-pull or alternate mode
`timescale 1ns/1ns
`include "port_cfg_defs.svh"
module port_pin_config_bank
    import port_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regHit,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] pinIn,
    output logic [31:0] pinData,
    output logic [31:0] padOe,
    output logic [31:0] padOut,
    output logic [31:0] pullupOn,
    output logic [7:0] analogSel,
    output logic [7:0] analogIn,
    output logic detectorRefSel,
    output logic serialRxIn,
    input wire logic serialRxOut,
    input wire logic serialTx,
    output logic timerACaptureIn,
    output logic timerAExtClockIn,
    input wire logic timerAOut,
    input wire logic timerBPwmOut,
    input wire logic [37:18] segmentLine
);
    // register file, its next values and the address of each entry
    logic [7:0] cfgReg [0:9];
    logic [7:0] cfgNext [0:9];
    logic [7:0] offs [0:9];
    // three sampling stages and the accepted pin levels
    logic [31:0] pinSync1Reg32, pinSync2Reg32, pinSync3Reg32;
    logic [31:0] pinDataReg, pinDataNext;
    // per-pin 2-bit codes, alternate sources and alternate selects
    logic [63:0] modeVec;
    logic [31:0] altOutVec, altSelVec;
    logic [7:0] p3High;

    // address of each register, in storage order
    assign offs[0] = `OFS_P2_CFG_HIGH;
    assign offs[1] = `OFS_P2_CFG_LOW;
    assign offs[2] = `OFS_P3_CFG_HIGH;
    assign offs[3] = `OFS_P3_CFG_LOW;
    assign offs[4] = `OFS_P4_CFG_HIGH;
    assign offs[5] = `OFS_P4_CFG_LOW;
    assign offs[6] = `OFS_P4_PULLUP;
    assign offs[7] = `OFS_P5_PULLUP;
    assign offs[8] = `OFS_P5_CFG_HIGH;
    assign offs[9] = `OFS_P5_CFG_LOW;

    // register write decode and read mux
    always_comb begin
        // unmapped addresses read zero and write nothing
        regRdata = 8'h00;
        regHit = 1'b0;
        for (int i = 0; i < 10; i++) begin
            cfgNext[i] = cfgReg[i];
            if (regAddr == offs[i]) begin
                regHit = 1'b1;
                regRdata = cfgReg[i];
                // a write strobe loads the addressed register
                if (regWrite) begin
                    cfgNext[i] = regWdata;
                end
            end
        end
        // port 3 high bits 7:6 have no storage
        // unused bits zero
        cfgNext[2] = cfgNext[2] & `P3H_IMPL_MASK;
    end

    // register storage
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 10; i++) begin
                cfgReg[i] <= `RST_CFG;
            end
        end else begin
            for (int i = 0; i < 10; i++) begin
                cfgReg[i] <= cfgNext[i];
            end
        end
    end

    // pin input synchroniser, change accepted once stages 2 and 3 agree
    always_comb begin
        pinDataNext = pinDataReg;
        for (int b = 0; b < 32; b++) begin
            // a pad still settling leaves the old level in place
            if (pinSync2Reg32[b] == pinSync3Reg32[b]) begin
                pinDataNext[b] = pinSync3Reg32[b];
            end
        end
    end

    // three sampling stages and the accepted levels
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pinSync1Reg32 <= 32'h0;
            pinSync2Reg32 <= 32'h0;
            pinSync3Reg32 <= 32'h0;
            pinDataReg <= 32'h0;
        end else begin
            pinSync1Reg32 <= pinIn;
            pinSync2Reg32 <= pinSync1Reg32;
            pinSync3Reg32 <= pinSync2Reg32;
            pinDataReg <= pinDataNext;
        end
    end

    // accepted levels leave from flip-flops
    assign pinData = pinDataReg;

    // pin modes: index 0..7 port 2, 8..15 port 3, 16..23 port 4, 24..31 port 5
    // each byte packs four 2-bit fields with the highest pin in bits 7:6
    assign modeVec = {
        // port 5 high then low byte
        cfgReg[8], cfgReg[9],
        // port 4 high then low byte
        cfgReg[4], cfgReg[5],
        // port 3: pins 15 and 14 have no pad and stay input
        // pins 13 and 12 come from the low half of the high byte
        4'h0, cfgReg[2][3:0], cfgReg[3],
        // port 2 high then low byte
        cfgReg[0], cfgReg[1]
    };
    // port 3 high byte also carries the alternate source selects
    assign p3High = cfgReg[2];

    // alternate output sources per pin
    always_comb begin
        // pins 14 and 15 keep this zero default
        altOutVec = 32'h0;
        altOutVec[7:0] = 8'h0;
        altOutVec[9] = p3High[`P3H_SEL_PIN1] ? segmentLine[35] : timerAOut;
        altOutVec[8] = p3High[`P3H_SEL_PIN0] ? segmentLine[34] : timerBPwmOut;
        altOutVec[10] = segmentLine[36];
        altOutVec[11] = segmentLine[37];
        altOutVec[12] = serialTx;
        altOutVec[13] = serialRxOut;
        altOutVec[23:16] = segmentLine[25:18];
        altOutVec[31:24] = segmentLine[33:26];
    end

    // per-pin decode, one decoder for every pin with a pad
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : gen_pin
            logic oe, pu, ao, as;
            // pins 14 and 15 have no pad: nothing driven or pulled
            if (g == 14 || g == 15) begin : gen_unused
                assign oe = 1'b0;
                assign ao = 1'b0;
                assign pu = 1'b0;
                assign as = 1'b0;
            end else begin : gen_used
                pin_mode_decode u_dec (
                    .mode(modeVec[2*g +: 2]),
                    .openDrainPort(g >= 16),
                    .pullupBit(g >= 24 ? cfgReg[7][g % 8] : cfgReg[6][g % 8]),
                    .pinOut(pinOut[g]),
                    .altOut(altOutVec[g]),
                    .padOe(oe),
                    .padOut(ao),
                    .pullupOn(pu),
                    .altSel(as)
                );
            end
            assign padOe[g] = (g < 8) ? (oe & ~as) : oe;
            assign padOut[g] = ao;
            assign pullupOn[g] = pu;
            assign altSelVec[g] = as;
        end
    endgenerate

    assign analogSel = altSelVec[7:0];
    // unselected analog channels read zero
    assign analogIn = pinDataReg[7:0] & altSelVec[7:0];
    // the reference input shares pin 7's analog code
    assign detectorRefSel = altSelVec[7];
    // routed inputs listen only in the two input codes
    // receiver input in input codes
    assign serialRxIn = ~modeVec[27] & pinDataReg[13];
    assign timerACaptureIn = ~modeVec[23] & pinDataReg[11];
    assign timerAExtClockIn = ~modeVec[21] & pinDataReg[10];
endmodule : port_pin_config_bank

/* verification/pad_partner.sv */
// pad wire model: driven, pulled up, or left floating
`timescale 1ns/1ns
module pad_partner (
    input wire logic mclk,
    input wire logic [31:0] padOe,
    input wire logic [31:0] padOut,
    input wire logic [31:0] pullupOn,
    output logic [31:0] pinIn
);
    logic [31:0] flt = 32'h0;
    // a floating line toggles so no stale level is read
    always @(posedge mclk) flt <= ~flt;
    assign pinIn = (padOe & padOut) | (~padOe & (pullupOn | flt));
endmodule : pad_partner

/* verification/port_cfg_sva.sv */
// assertions on the port configuration bank ports
`timescale 1ns/1ns
`include "port_cfg_defs.svh"
module port_cfg_check (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regHit,
    input wire logic [31:0] pinOut,
    input wire logic [31:0] padOe,
    input wire logic [31:0] padOut,
    input wire logic [31:0] pullupOn,
    input wire logic [7:0] analogSel,
    input wire logic [37:18] segmentLine
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // pull-up write then a read of the same place
    sequence s_pullWr;
        regWrite && regAddr == `OFS_P4_PULLUP ##1 regAddr == `OFS_P4_PULLUP;
    endsequence
    property p_wrLands; s_pullWr |-> regRdata == $past(regWdata); endproperty
    a_wrLands: assert property (p_wrLands) else $error("write late");
    property p_rstClr; $rose(rst_b) |-> padOe == 32'h0 && pullupOn == 32'h0; endproperty
    a_rstClr: assert property (p_rstClr) else $error("not cleared");
    property p_unmap; !regHit |-> regRdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_p2An; regAddr == `OFS_P2_CFG_LOW && regRdata[1:0] == 2'h3 |-> analogSel[0] && !padOe[0]; endproperty
    a_p2An: assert property (p_p2An) else $error("analog pin");
    property p_p3Push;
        regAddr == `OFS_P3_CFG_LOW && regRdata[7:6] == 2'h2 |-> padOe[11] && padOut[11] == pinOut[11];
    endproperty
    a_p3Push: assert property (p_p3Push) else $error("push pin");
    property p_p4Seg;
        regAddr == `OFS_P4_CFG_LOW && regRdata[1:0] == 2'h3 |-> padOe[16] && padOut[16] == segmentLine[18];
    endproperty
    a_p4Seg: assert property (p_p4Seg) else $error("segment pin");
    property p_p4Pull; regAddr == `OFS_P4_PULLUP |-> (pullupOn[23:16] & ~regRdata) == 8'h00; endproperty
    a_p4Pull: assert property (p_p4Pull) else $error("pull-up on");
    property p_p5Od;
        regAddr == `OFS_P5_CFG_LOW && regRdata[1:0] == 2'h1 |-> !padOut[24] && padOe[24] == !pinOut[24];
    endproperty
    a_p5Od: assert property (p_p5Od) else $error("open drain");
endmodule : port_cfg_check

/* verification/tb.sv */
// self-checking bench for the port configuration bank
`timescale 1ns/1ns
`include "port_cfg_defs.svh"
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin errTotal++; $display("CHECK FAILED %s %h %h", nm, e, g); end end
module tb;
    logic mclk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, serialRxOut = 1'b0, serialTx = 1'b0;
    logic timerAOut = 1'b0, timerBPwmOut = 1'b0, regHit, detectorRefSel, serialRxIn, timerACaptureIn;
    logic timerAExtClockIn;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, analogSel, analogIn;
    logic [31:0] pinOut = 32'h0, pinIn, pinData, padOe, padOut, pullupOn;
    logic [37:18] segmentLine = 20'h0;
    logic [7:0] mdl [256];
    logic [7:0] ofs [10] = '{`OFS_P2_CFG_HIGH, `OFS_P2_CFG_LOW, `OFS_P3_CFG_HIGH, `OFS_P3_CFG_LOW,
        `OFS_P4_CFG_HIGH, `OFS_P4_CFG_LOW, `OFS_P4_PULLUP, `OFS_P5_PULLUP, `OFS_P5_CFG_HIGH, `OFS_P5_CFG_LOW};
    int hiIdx [4] = '{0, 2, 4, 8};
    int errTotal = 0, nTests = 0;
    always #2 mclk = ~mclk;
    port_pin_config_bank u_dut (.mclk, .rst_b, .regAddr, .regWrite, .regWdata, .regRdata, .regHit, .pinOut,
        .pinIn, .pinData, .padOe, .padOut, .pullupOn, .analogSel, .analogIn, .detectorRefSel, .serialRxIn,
        .serialRxOut, .serialTx, .timerACaptureIn, .timerAExtClockIn, .timerAOut, .timerBPwmOut, .segmentLine);
    pad_partner u_pads (.mclk, .padOe, .padOut, .pullupOn, .pinIn);
    // field of pin i from the model registers
    function automatic logic [1:0] code(int i);
        logic [7:0] r;
        r = mdl[ofs[hiIdx[i / 8] + int'(i % 8 < 4)]];
        return r[2 * (i % 4) +: 2];
    endfunction : code
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrite <= 1'b1;
        regWdata <= d;
        foreach (ofs[k]) if (ofs[k] == a) mdl[a] = a == `OFS_P3_CFG_HIGH ? d & `P3H_IMPL_MASK : d;
    endtask : wr
    task automatic rd(logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regWrite <= 1'b0;
        @(negedge mclk);
        `CHK("regRdata", mdl[a], regRdata)
    endtask : rd
    // expected pin controls from the model
    task automatic chk();
        logic [31:0] eOe, eOut, ePu, m;
        logic [7:0] eAn, s;
        logic [7:0] a3;
        logic [1:0] c;
        s = mdl[`OFS_P3_CFG_HIGH];
        a3 = {2'h0, serialRxOut, serialTx, segmentLine[37:36], s[5] ? segmentLine[35] : timerAOut,
            s[4] ? segmentLine[34] : timerBPwmOut};
        m = 32'hffff3fff;
        for (int i = 0; i < 32; i++) begin
            c = code(i);
            eOe[i] = c == 2'h2 || (c == 2'h3 && i > 7) || (c == 2'h1 && i > 15 && !pinOut[i]);
            eOut[i] = c == 2'h2 ? pinOut[i] : c == 2'h1 ? 1'b0 : i < 16 ? a3[i % 8] : segmentLine[i + 2];
            ePu[i] = i > 15 ? c < 2'h2 && mdl[ofs[6 + int'(i > 23)]][i % 8] : c == 2'h1;
            if (i < 8) eAn[i] = c == 2'h3;
        end
        `CHK("padOe", eOe & m, padOe & m)
        `CHK("padOut", eOut & eOe & m, padOut & eOe & m)
        `CHK("pullupOn", ePu & m & 32'h00ffffff, pullupOn & m & 32'h00ffffff)
        `CHK("pullupOn5", ePu[31:24], pullupOn[31:24])
        `CHK("analogSel", eAn, analogSel)
        `CHK("detectorRefSel", eAn[7], detectorRefSel)
        `CHK("analogIn", 8'h00, analogIn & ~eAn)
        `CHK("pinData", (eOut & eOe | ePu & ~eOe) & m, pinData & (eOe | ePu) & m)
        if (code(11) != 2'h0) `CHK("timerACaptureIn", code(11) == 2'h1, timerACaptureIn)
        if (code(10) != 2'h0) `CHK("timerAExtClockIn", code(10) == 2'h1, timerAExtClockIn)
        if (code(13) != 2'h0) `CHK("serialRxIn", code(13) == 2'h1, serialRxIn)
    endtask : chk
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    // reset, then random configurations with full readback
    initial begin
        void'($urandom(32'h01b192ec));
        foreach (mdl[k]) mdl[k] = 8'h00;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        for (int n = 0; n < 60; n++) begin
            foreach (ofs[k]) rd(ofs[k]);
            rd(8'hf0);
            chk();
            $display("test %0d done", n);
            foreach (ofs[k]) wr(ofs[k], 8'($urandom));
            wr(8'hf0, 8'hff);
            wr(ofs[6], 8'($urandom));
            rd(ofs[6]);
            @(posedge mclk);
            pinOut <= $urandom;
            segmentLine <= 20'($urandom);
            {serialRxOut, serialTx, timerAOut, timerBPwmOut} <= 4'($urandom);
            repeat (6) @(posedge mclk);
        end
        // reset in mid-run returns every register, output enable and pull-up to zero
        @(posedge mclk);
        rst_b <= 1'b0;
        foreach (mdl[k]) mdl[k] = 8'h00;
        @(posedge mclk);
        rst_b <= 1'b1;
        foreach (ofs[k]) rd(ofs[k]);
        chk();
        $display("reset test done");
        conclude();
    end
endmodule : tb
bind port_pin_config_bank port_cfg_check u_chk (.mclk, .rst_b, .regAddr, .regWrite, .regWdata, .regRdata,
    .regHit, .pinOut, .padOe, .padOut, .pullupOn, .analogSel, .segmentLine);
